// [rtl/mcuclk_defs.svh]
// Functional notes
// - Machine cycle equals two CPU core clocks
// - Peripheral clock is CPU core clock halved
// - Source clock from four strapped oscillator choices
// - Clock out only without crystal anywhere
// - Clock out drives only when enable set
// - Clock out toggles at half core clock
// - Six-bit RC trim, factory value, writable
// - Crystal wake delay 992 cycles plus 60us
// - Other sources wake delay 224 plus 60us
// - Divider up to 510, changeable anytime
// - Every reset clears low-power clock select
// - Only power-on reset reloads trim register
// - Trim register layout: RC, enable, trim
`ifndef MCUCLK_DEFS_SVH
`define MCUCLK_DEFS_SVH

// ****************************************
// Register offsets and fields
// ****************************************
`define MCUCLK_TRIM_ADDR      8'h96
`define MCUCLK_TRIM_RC_BIT    7
`define MCUCLK_TRIM_EN_BIT    6
`define MCUCLK_TRIM_VAL_MSB   5
`define MCUCLK_AUX1_LP_BIT    7
`define MCUCLK_CPU_CLOCK_DIVIDER_RST       8'h00
`define MCUCLK_LP_RST         1'b0

// ****************************************
// Timing counts
// ****************************************
`define MCUCLK_CLK_MHZ        125
`define MCUCLK_WAKE_US_MIN    60
`define MCUCLK_WAKE_US_CYC    (`MCUCLK_WAKE_US_MIN * `MCUCLK_CLK_MHZ)
`define MCUCLK_XTAL_CYC       10'h3e0
`define MCUCLK_OTHER_CYC      10'h0e0

`endif

// [rtl/mcuclk_pkg.sv]
package mcuclk_pkg;
  // Strapped source choice
  typedef enum logic [1:0] {
    MCUCLK_SRC_WDOG = 2'b00,
    MCUCLK_SRC_IRC  = 2'b01,
    MCUCLK_SRC_XTAL = 2'b10,
    MCUCLK_SRC_EXT  = 2'b11
  } mcuclk_src_t;

  // Wake-up timer states
  typedef enum logic [0:0] {
    MCUCLK_WK_WAIT = 1'b0,
    MCUCLK_WK_RUN  = 1'b1
  } mcuclk_wake_st_t;
endpackage : mcuclk_pkg

// [rtl/mcuclk_wake_if.sv]
`timescale 1ns/1ns
`default_nettype none
// Link between clock top and wake-up timer
interface mcuclk_wake_if;
  logic src_tick;   // One pulse per source clock rising edge
  logic start;      // Restart the wake delay
  logic is_xtal;    // Crystal source selected
  logic ready;      // Core clock may run
  modport top  (output src_tick, output start, output is_xtal, input ready);
  modport timer(input src_tick, input start, input is_xtal, output ready);
endinterface : mcuclk_wake_if
`default_nettype wire

// [rtl/mcuclk_wake.sv]
`timescale 1ns/1ns
`default_nettype none
`include "mcuclk_defs.svh"
module mcuclk_wake
  import mcuclk_pkg::*;
#(
  parameter int unsigned US_CYC = `MCUCLK_WAKE_US_CYC
) (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       ce_i,
  // Link to top
  mcuclk_wake_if.timer    wk
);
  // ****************************************
  // Counters
  // ****************************************
  mcuclk_wake_st_t st_reg, st_next;   // Gate state
  logic [9:0]      src_cnt_reg;       // Source cycles seen
  logic [15:0]     us_cnt_reg;        // System cycles seen
  logic            ready_reg;         // Registered gate release

  // Targets by source kind
  wire logic [9:0]  src_target = wk.is_xtal ? `MCUCLK_XTAL_CYC : `MCUCLK_OTHER_CYC;
  wire logic        src_done   = (src_cnt_reg >= src_target);
  wire logic        us_done    = (us_cnt_reg >= 16'(US_CYC));
  // Microsecond part runs after the source count; shortest legal figure used
  wire logic        all_done   = src_done && us_done;

  // Next state decode
  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      MCUCLK_WK_WAIT: if (all_done) st_next = MCUCLK_WK_RUN;
      MCUCLK_WK_RUN:  st_next = MCUCLK_WK_RUN;
    endcase
    if (wk.start) st_next = MCUCLK_WK_WAIT;
  end

  // Count while waiting, restart on request
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg      <= MCUCLK_WK_WAIT;
      src_cnt_reg <= 10'h000;
      us_cnt_reg  <= 16'h0000;
      ready_reg   <= 1'b0;
    end else if (ce_i) begin
      st_reg    <= st_next;
      ready_reg <= (st_next == MCUCLK_WK_RUN);
      if (wk.start) begin
        src_cnt_reg <= 10'h000;
        us_cnt_reg  <= 16'h0000;
      end else if (st_reg == MCUCLK_WK_WAIT) begin
        // Saturate so a slow source cannot wrap
        if (wk.src_tick && !src_done) src_cnt_reg <= src_cnt_reg + 10'h001;
        if (src_done && !us_done)     us_cnt_reg  <= us_cnt_reg + 16'h0001;
      end
    end
  end

  assign wk.ready = ready_reg;
endmodule : mcuclk_wake
`default_nettype wire

// [rtl/mcuclk_top.sv]
`timescale 1ns/1ns
`default_nettype none
`include "mcuclk_defs.svh"
module mcuclk_top
  import mcuclk_pkg::*;
#(
  parameter int unsigned WAKE_US_CYC = `MCUCLK_WAKE_US_CYC
) (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       ce_i,
  input  wire logic       reset_req_i,
  input  wire logic       pd_exit_i,
  // Oscillator pins
  input  wire logic       wdog_osc_i,
  input  wire logic       internal_rc_clock_i,
  input  wire logic       xtal_osc_i,
  input  wire logic       external_clock_pin_i,
  // Configuration
  input  wire logic [1:0] cfg_src_sel_i,
  input  wire logic       rtc_on_xtal_i,
  input  wire logic [7:0] factory_trim_i,
  // Software writes
  input  wire logic       trim_wr_i,
  input  wire logic [7:0] trim_wdata_i,
  input  wire logic       cpu_clock_divider_wr_i,
  input  wire logic [7:0] cpu_clock_divider_wdata_i,
  input  wire logic       aux1_wr_i,
  input  wire logic [7:0] aux1_wdata_i,
  // Clock outputs
  output logic            cpu_core_clock_o,
  output logic            periph_clock_o,
  output logic            machine_cycle_o,
  output logic            clock_ready_o,
  output logic            clock_output_pin_o,
  output logic            clock_output_pin_oe_b_o,
  // Status
  output logic [7:0]      trim_o,
  output logic [7:0]      cpu_clock_divider_o,
  output logic            low_power_clock_select_o,
  output logic [1:0]      src_sel_o
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [3:0] osc_s1_reg;   // First stage only feeds second
  logic [3:0] osc_s2_reg;   // Second stage
  logic [3:0] osc_s3_reg;   // Edge history
  // Pins packed so one loop serves all four
  wire  logic [3:0] osc_raw = {external_clock_pin_i, xtal_osc_i, internal_rc_clock_i, wdog_osc_i};

  // One three-flop chain per oscillator pin
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          // Low matches an idle oscillator
          osc_s1_reg[gi] <= 1'b0;
          osc_s2_reg[gi] <= 1'b0;
          osc_s3_reg[gi] <= 1'b0;
        end else if (ce_i) begin
          osc_s1_reg[gi] <= osc_raw[gi];
          osc_s2_reg[gi] <= osc_s1_reg[gi];
          osc_s3_reg[gi] <= osc_s2_reg[gi];
        end
      end
    end
  endgenerate

  // ****************************************
  // Source selection
  // ****************************************
  // The strap is caught once; reset requests keep it
  mcuclk_src_t src_reg;        // Strap caught after reset release
  logic        strap_done_reg; // Strap and factory trim taken
  // Rising edge seen on the synchronised level
  wire  logic [3:0] osc_rise = osc_s2_reg & ~osc_s3_reg;
  // Source edge from the strapped oscillator
  wire  logic  src_tick  = osc_rise[src_reg];
  wire  logic  src_xtal  = (src_reg == MCUCLK_SRC_XTAL);

  // ****************************************
  // Registers
  // ****************************************
  // Software-visible state
  logic [7:0] trim_reg;        // RC select, clock-out enable, trim
  logic [7:0] cpu_clock_divider_reg;        // Divider setting
  logic       lp_reg;          // Low-power access select
  // Low-power bit may only be set at 8 MHz or less; software owns that
  wire  logic lp_next = aux1_wdata_i[`MCUCLK_AUX1_LP_BIT];

  // Strap and factory trim load only after power-on release
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      strap_done_reg <= 1'b0;
      src_reg        <= MCUCLK_SRC_WDOG;
      trim_reg       <= 8'h00;
    end else if (ce_i) begin
      if (!strap_done_reg) begin
        // First enabled edge after power-on release
        strap_done_reg <= 1'b1;
        src_reg        <= mcuclk_src_t'(cfg_src_sel_i);
        trim_reg       <= factory_trim_i;
      end else if (trim_wr_i) begin
        // Other resets leave trim untouched
        trim_reg <= trim_wdata_i;
      end
    end
  end

  // Divider and low-power bit, cleared by every reset source
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cpu_clock_divider_reg <= `MCUCLK_CPU_CLOCK_DIVIDER_RST;
      lp_reg   <= `MCUCLK_LP_RST;
    end else if (ce_i) begin
      if (reset_req_i) begin
        // Other reset sources win over any write
        cpu_clock_divider_reg <= `MCUCLK_CPU_CLOCK_DIVIDER_RST;
        lp_reg   <= `MCUCLK_LP_RST;
      end else begin
        // Writes land at once; divider compares against them in the period in progress
        if (cpu_clock_divider_wr_i) cpu_clock_divider_reg <= cpu_clock_divider_wdata_i;
        if (aux1_wr_i) lp_reg   <= lp_next;
      end
    end
  end

  // ****************************************
  // Wake-up timer
  // ****************************************
  // Timer restarts on power-on, reset request or power-down exit
  mcuclk_wake_if wk_if();
  logic first_reg;   // Start pulse after power-on release
  assign wk_if.src_tick = src_tick;
  assign wk_if.is_xtal  = src_xtal;
  assign wk_if.start    = (!first_reg && strap_done_reg) || reset_req_i || pd_exit_i;

  // Source count first, then the microsecond count
  mcuclk_wake #(
    .US_CYC    (WAKE_US_CYC)
  ) u_wake (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .ce_i      (ce_i),
    .wk        (wk_if.timer)
  );

  // ****************************************
  // CPU clock divider
  // ****************************************
  logic [8:0] div_cnt_reg;   // Source ticks in this period
  logic       mc_phase_reg;  // Half of a machine cycle
  // Zero passes every source edge, else divide by twice the value
  wire  logic [8:0] div_last = (cpu_clock_divider_reg == 8'h00) ? 9'h000 : 9'({cpu_clock_divider_reg, 1'b0} - 9'h001);
  wire  logic cpu_core_clock_tick = wk_if.ready && src_tick && (div_cnt_reg >= div_last);
  // Clock out only without crystal in use
  wire  logic cko_allow = !src_xtal && !rtc_on_xtal_i;
  wire  logic cko_on    = cko_allow && trim_reg[`MCUCLK_TRIM_EN_BIT];

  // Period count; new setting applies to the period in progress, no stall
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_cnt_reg <= 9'h000;
      first_reg   <= 1'b0;
    end else if (ce_i) begin
      // Start pulse is one cycle wide
      if (strap_done_reg) first_reg <= 1'b1;
      // Counter held at zero while gated
      if (!wk_if.ready)  div_cnt_reg <= 9'h000;
      else if (cpu_core_clock_tick) div_cnt_reg <= 9'h000;
      else if (src_tick)  div_cnt_reg <= div_cnt_reg + 9'h001;
    end
  end

  // Registered clock outputs
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cpu_core_clock_o        <= 1'b0;
      periph_clock_o          <= 1'b0;
      machine_cycle_o         <= 1'b0;
      mc_phase_reg            <= 1'b0;
      clock_output_pin_o      <= 1'b0;
      clock_output_pin_oe_b_o <= 1'b1;
      clock_ready_o           <= 1'b0;
    end else if (ce_i) begin
      // One-cycle pulse per core clock
      cpu_core_clock_o <= cpu_core_clock_tick;
      clock_ready_o    <= wk_if.ready;
      machine_cycle_o  <= cpu_core_clock_tick && mc_phase_reg;
      if (cpu_core_clock_tick) begin
        mc_phase_reg   <= ~mc_phase_reg;
        periph_clock_o <= ~periph_clock_o;
      end
      // Pin released when disabled; saves power in idle
      clock_output_pin_oe_b_o <= ~cko_on;
      // Pin parked low while released
      if (!cko_on)        clock_output_pin_o <= 1'b0;
      else if (cpu_core_clock_tick) clock_output_pin_o <= ~clock_output_pin_o;
    end
  end

  // Status readback
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      trim_o                   <= 8'h00;
      cpu_clock_divider_o                   <= 8'h00;
      low_power_clock_select_o <= 1'b0;
      src_sel_o                <= 2'h0;
    end else if (ce_i) begin
      // Copies lag the registers by one cycle
      trim_o                   <= trim_reg;
      cpu_clock_divider_o                   <= cpu_clock_divider_reg;
      low_power_clock_select_o <= lp_reg;
      src_sel_o                <= src_reg;
    end
  end
endmodule : mcuclk_top
`default_nettype wire

// [verif/mcuclk_monitor.sv]
`timescale 1ns/1ns
`default_nettype none
`include "mcuclk_defs.svh"
// ****************************************
// Port checker for the clock block
// ****************************************
module mcuclk_monitor
  import mcuclk_pkg::*;
#(
  parameter int unsigned WAKE_US_CYC = `MCUCLK_WAKE_US_CYC
) (
  // Clock, resets and causes
  input wire logic       sys_clk_i,
  input wire logic       rst_b_i,
  input wire logic       reset_req_i,
  input wire logic       pd_exit_i,
  input wire logic       rtc_on_xtal_i,
  input wire logic       trim_wr_i,
  // Watched outputs
  input wire logic       cpu_core_clock_o,
  input wire logic       periph_clock_o,
  input wire logic       machine_cycle_o,
  input wire logic       clock_ready_o,
  input wire logic       clock_output_pin_o,
  input wire logic       clock_output_pin_oe_b_o,
  input wire logic [7:0] trim_o,
  input wire logic       low_power_clock_select_o,
  input wire logic [1:0] src_sel_o
);
  logic [15:0] wake_cnt_reg;  // Cycles since last wake restart
  int          wake_min;      // Source edges taken as four clocks apart, as the test drives them
  assign wake_min = (src_sel_o == MCUCLK_SRC_XTAL) ? 3964 : 892;
  // Counting from the cause overestimates the wait, so the bound stays safe
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) wake_cnt_reg <= 16'h0000;
    else if (pd_exit_i || reset_req_i) wake_cnt_reg <= 16'h0000;
    else if (wake_cnt_reg != 16'hffff) wake_cnt_reg <= wake_cnt_reg + 16'h0001;
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_core; cpu_core_clock_o; endsequence
  sequence s_rtc_held; rtc_on_xtal_i ##1 rtc_on_xtal_i ##1 rtc_on_xtal_i; endsequence
  sequence s_soft_reset; reset_req_i && !trim_wr_i; endsequence
  property p_mcyc; machine_cycle_o |-> s_core; endproperty
  property p_periph; s_core |-> $changed(periph_clock_o); endproperty
  property p_gate; !clock_ready_o |-> !cpu_core_clock_o; endproperty
  property p_oe_rtc; s_rtc_held |-> clock_output_pin_oe_b_o; endproperty
  property p_oe_xtal; src_sel_o == MCUCLK_SRC_XTAL |-> clock_output_pin_oe_b_o && !clock_output_pin_o; endproperty
  property p_pin;
    !clock_output_pin_oe_b_o && !$past(clock_output_pin_oe_b_o) && cpu_core_clock_o |-> $changed(clock_output_pin_o);
  endproperty
  property p_lp; reset_req_i |-> ##2 !low_power_clock_select_o; endproperty
  property p_trim; s_soft_reset |-> ##2 $stable(trim_o); endproperty
  property p_wake; $rose(clock_ready_o) |-> wake_cnt_reg >= wake_min + WAKE_US_CYC; endproperty
  a_mcyc: assert property (p_mcyc) else $error("machine cycle off a core tick");
  a_periph: assert property (p_periph) else $error("peripheral clock missed a core tick");
  a_gate: assert property (p_gate) else $error("core tick before ready");
  a_oe_rtc: assert property (p_oe_rtc) else $error("clock out driven with rtc on crystal");
  a_oe_xtal: assert property (p_oe_xtal) else $error("clock out driven with crystal source");
  a_pin: assert property (p_pin) else $error("clock out missed a core tick");
  a_lp: assert property (p_lp) else $error("low power select kept over reset");
  a_trim: assert property (p_trim) else $error("trim changed on soft reset");
  a_wake: assert property (p_wake) else $error("wake delay too short");
endmodule : mcuclk_monitor
`default_nettype wire

// [verif/mcu_clock_generation_test.sv]
`timescale 1ns/1ns
`default_nettype none
module mcu_clock_generation_test;
  import mcuclk_pkg::*;
  localparam int unsigned WK = 20;  // Short microsecond delay keeps the run brief
  logic       sys_clk_i = 1'b0, rst_b_i = 1'b0, ce_i = 1'b1, reset_req_i = 1'b0, pd_exit_i = 1'b0;
  logic       rtc_on_xtal_i = 1'b0, trim_wr_i = 1'b0, cpu_clock_divider_wr_i = 1'b0, aux1_wr_i = 1'b0;
  logic       osc = 1'b0, osc_ph = 1'b0;
  logic [1:0] cfg_src_sel_i = 2'b00, src_sel_o;
  logic [7:0] factory_trim_i = 8'h00, trim_wdata_i = 8'h00, cpu_clock_divider_wdata_i = 8'h00, aux1_wdata_i = 8'h00;
  logic [7:0] trim_o, cpu_clock_divider_o;
  logic       cpu_core_clock_o, periph_clock_o, machine_cycle_o, clock_ready_o;
  logic       clock_output_pin_o, clock_output_pin_oe_b_o, low_power_clock_select_o;
  int         n_errors = 0, n_checks = 0;
  always #4 sys_clk_i = ~sys_clk_i;
  // Source levels last two clocks, twice the shortest the synchroniser takes
  always @(negedge sys_clk_i) begin
    osc_ph <= ~osc_ph;
    if (osc_ph) osc <= ~osc;
  end
  mcuclk_top #(.WAKE_US_CYC(WK)) dut_u (
    .sys_clk_i, .rst_b_i, .ce_i, .reset_req_i, .pd_exit_i, .wdog_osc_i(osc), .internal_rc_clock_i(osc),
    .xtal_osc_i(osc), .external_clock_pin_i(osc), .cfg_src_sel_i, .rtc_on_xtal_i, .factory_trim_i,
    .trim_wr_i, .trim_wdata_i, .cpu_clock_divider_wr_i, .cpu_clock_divider_wdata_i, .aux1_wr_i, .aux1_wdata_i, .cpu_core_clock_o,
    .periph_clock_o, .machine_cycle_o, .clock_ready_o, .clock_output_pin_o, .clock_output_pin_oe_b_o,
    .trim_o, .cpu_clock_divider_o, .low_power_clock_select_o, .src_sel_o);
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  function automatic logic pick(input int which);
    case (which)
      0: return cpu_core_clock_o;
      1: return machine_cycle_o;
      2: return periph_clock_o;
      3: return clock_output_pin_o;
      default: return clock_ready_o;
    endcase
  endfunction : pick
  // Bounded wait for a level; a hang ends the run
  task automatic wait_lvl(input int which, input logic lvl, output int cyc);
    cyc = 0;
    do begin
      @(negedge sys_clk_i);
      cyc++;
    end while (pick(which) !== lvl && cyc < 20000);
    if (cyc >= 20000) begin
      check("wait bound", 1'b1, 1'b0);
      end_of_test();
    end
  endtask : wait_lvl
  task automatic gap_of(input int which, output int gap);
    int a, b;
    wait_lvl(which, 1'b0, a);
    wait_lvl(which, 1'b1, a);
    wait_lvl(which, 1'b0, a);
    wait_lvl(which, 1'b1, b);
    gap = a + b;
  endtask : gap_of
  // Ready must fall, then rise after the source count plus the microsecond part
  task automatic wake(input mcuclk_src_t s);
    int a, b, n;
    n = (s == MCUCLK_SRC_XTAL) ? 992 * 4 : 224 * 4;
    n = n + WK;
    wait_lvl(4, 1'b0, a);
    wait_lvl(4, 1'b1, b);
    check("wake", (a + b >= n - 4) && (a + b <= n + 16), 1'b1);
    $display("wake test done");
  endtask : wake
  task automatic wr(input int sel, input logic [7:0] d);
    trim_wr_i = (sel == 0);
    cpu_clock_divider_wr_i = (sel == 1);
    aux1_wr_i = (sel == 2);
    {trim_wdata_i, cpu_clock_divider_wdata_i, aux1_wdata_i} = {d, d, d};
    @(negedge sys_clk_i);
    {trim_wr_i, cpu_clock_divider_wr_i, aux1_wr_i} = 3'b000;
    repeat (3) @(negedge sys_clk_i);
  endtask : wr
  initial begin
    mcuclk_src_t s;
    logic [7:0]  d;
    int          g, c;
    void'($urandom(10346));
    // Crystal first, then the three other straps
    for (int k = 0; k < 4; k++) begin
      s = mcuclk_src_t'(2'(k + 2));
      d = 8'($urandom);
      @(negedge sys_clk_i);
      rst_b_i = 1'b0;
      cfg_src_sel_i = s;
      factory_trim_i = d;
      repeat (6) @(negedge sys_clk_i);
      rst_b_i = 1'b1;
      wake(s);
      check("src", src_sel_o, s);
      check("factory trim", trim_o, d);
      // Divider at its maximum, bypassed, then slow enough for low power
      for (int j = 0; j < 3; j++) begin
        d = (j == 0) ? 8'hff : (j == 1) ? 8'h00 : 8'($urandom_range(4, 2));
        wr(1, d);
        check("cpu_clock_divider", cpu_clock_divider_o, d);
        gap_of(0, g);
        gap_of(0, g);
        check("core gap", g, (d == 8'h00) ? 4 : d * 8);
      end
      gap_of(1, c);
      check("machine gap", c, 2 * g);
      gap_of(2, c);
      check("periph gap", c, 2 * g);
      d = {2'b01, 6'($urandom)};
      wr(0, d);
      check("trim", trim_o, d);
      if (s != MCUCLK_SRC_XTAL) begin
        check("out driven", clock_output_pin_oe_b_o, 1'b0);
        gap_of(3, c);
        check("out gap", c, 2 * g);
        rtc_on_xtal_i = 1'b1;
        repeat (4) @(negedge sys_clk_i);
        check("out rtc", clock_output_pin_oe_b_o, 1'b1);
        rtc_on_xtal_i = 1'b0;
      end else begin
        check("out xtal", clock_output_pin_oe_b_o, 1'b1);
      end
      d = {2'b10, d[5:0]};
      wr(0, d);
      check("out off", {clock_output_pin_oe_b_o, clock_output_pin_o}, 2'b10);
      wr(2, 8'h80);
      check("low power", low_power_clock_select_o, 1'b1);
      // Freeze between core pulses so no output stalls mid-pulse
      wait_lvl(0, 1'b0, c);
      ce_i = 1'b0;
      wr(1, 8'h05);
      check("ce hold", cpu_clock_divider_o, 8'(g / 8));
      ce_i = 1'b1;
      reset_req_i = 1'b1;
      @(negedge sys_clk_i);
      reset_req_i = 1'b0;
      wake(s);
      check("lp cleared", {low_power_clock_select_o, cpu_clock_divider_o}, 9'h000);
      check("trim kept", trim_o, d);
      pd_exit_i = 1'b1;
      @(negedge sys_clk_i);
      pd_exit_i = 1'b0;
      wake(s);
    end
    end_of_test();
  end
endmodule : mcu_clock_generation_test
bind mcuclk_top mcuclk_monitor #(.WAKE_US_CYC(WAKE_US_CYC)) mon_u (.sys_clk_i, .rst_b_i, .reset_req_i,
  .pd_exit_i, .rtc_on_xtal_i, .trim_wr_i, .cpu_core_clock_o, .periph_clock_o, .machine_cycle_o,
  .clock_ready_o, .clock_output_pin_o, .clock_output_pin_oe_b_o, .trim_o, .low_power_clock_select_o,
  .src_sel_o);
`default_nettype wire
